// *** hdl/ast_pkg.sv ***
// shared constants and types for the asynchronous serial transceiver
package ast_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] OFS_MODE = 3'h0;
  localparam logic [2:0] OFS_ERR = 3'h1;
  localparam logic [2:0] OFS_BAUD = 3'h2;
  localparam logic [2:0] OFS_TXDATA = 3'h3;
  localparam logic [2:0] OFS_RXBUF = 3'h4;
  localparam logic [2:0] OFS_IRQSTAT = 3'h5;
  localparam logic [2:0] OFS_IRQMASK = 3'h6;
  localparam logic [2:0] OFS_STATE = 3'h7;
  // serial_mode_register fields
  localparam int MODE_TXE = 7;
  localparam int MODE_RXE = 6;
  localparam int MODE_EXTCLK = 4;
  localparam int MODE_PAR_EN = 3;
  localparam int MODE_PAR_ODD = 2;
  localparam int MODE_ERR_SUPPRESS = 1;
  localparam int MODE_SEVEN = 0;
  // receive_error_status fields
  localparam int ERR_PARITY = 2;
  localparam int ERR_FRAMING = 1;
  localparam int ERR_OVERRUN = 0;
  // baud_divider_control fields
  localparam int BAUD_N_HI = 6;
  localparam int BAUD_N_LO = 4;
  localparam int BAUD_K_HI = 3;
  localparam logic [3:0] BAUD_K_MAX = 4'hE;
  localparam logic [4:0] BAUD_K_BASE = 5'h10;
  // interrupt status / mask fields
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] ERR_RESET = 8'h00;
  localparam logic [6:0] BAUD_RESET = 7'h10;
  localparam logic [7:0] TXDATA_RESET = 8'hFF;
  localparam logic [7:0] RXBUF_RESET = 8'h00;
  // frame timing: prescaler step of one, frame length in bits
  localparam logic [3:0] TX_BITS_BASE = 4'hA;
  localparam logic [7:0] PRESC_ONE = 8'h01;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ast_rx_state_type;
endpackage

// *** hdl/ast_baud.sv ***
// baud generator: source select, 2^n prescaler and 5-bit counter
`timescale 1ns/1ns
module ast_baud
  import ast_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic extSel,
  input wire logic [2:0] prescSel,
  input wire logic [3:0] divSet,
  input wire logic extClk,
  // half-bit enable pulse
  output logic halfTick
);
  typedef struct packed {
    logic [7:0] presc;
    logic [4:0] div;
    logic extPrev;
  } ast_baud_state_type;

  ast_baud_state_type st;
  ast_baud_state_type next_st;
  logic srcTick;
  logic prescTick;
  logic [3:0] kEff;

  // counter source is either every clock or each rising edge of the pin
  assign srcTick = extSel ? (extClk & ~st.extPrev) : 1'b1;
  // k beyond fourteen is clamped so the counter never runs past its range
  assign kEff = (divSet > BAUD_K_MAX) ? BAUD_K_MAX : divSet;
  // prescaler divides by 2^n, n from a three-bit field
  // compares use >= so a smaller setting written mid-count wraps at once, not after overflow
  assign prescTick = srcTick && (st.presc >= (PRESC_ONE << prescSel) - PRESC_ONE);

  // half-bit tick every 2^n*(k+16) source clocks; a bit is two of them
  always_comb
  begin
    next_st = st;
    halfTick = 1'b0;
    next_st.extPrev = extClk;
    if (!run)
    begin
      next_st.presc = '0;
      next_st.div = '0;
    end
    else if (srcTick)
    begin
      if (prescTick)
      begin
        next_st.presc = '0;
        if (st.div >= BAUD_K_BASE + {1'b0, kEff} - 5'h01)
        begin
          next_st.div = '0;
          halfTick = 1'b1;
        end
        else
          next_st.div = st.div + 5'h01;
      end
      else
        next_st.presc = st.presc + 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

// *** hdl/ast_rx.sv ***
// receive shifter: start detect, data, parity and stop sampling
`timescale 1ns/1ns
module ast_rx
  import ast_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic halfTick,
  input wire logic sevenBit,
  input wire logic parEn,
  input wire logic parOdd,
  // serial line
  input wire logic rxIn,
  // frame result
  output logic frameDone,
  output logic [7:0] frameData,
  output logic parityErr,
  output logic framingErr
);
  typedef struct packed {
    ast_rx_state_type fsm;
    logic phase;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic par;
    logic done;
    logic [7:0] data;
    logic pErr;
    logic fErr;
  } ast_rx_reg_type;

  ast_rx_reg_type st;
  ast_rx_reg_type next_st;
  logic sampleNow;

  // a bit is sampled every second half tick, near its middle
  assign sampleNow = halfTick && st.phase;

  // one always_comb for the whole receive sequence
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (halfTick)
      next_st.phase = ~st.phase;
    unique case (st.fsm)
      RX_IDLE:
        if (halfTick && !rxIn)
        begin
          next_st.fsm = RX_START;
          next_st.phase = 1'b0;
        end
      RX_START:
        // a glitch shorter than half a bit is dropped here
        if (halfTick)
        begin
          next_st.fsm = rxIn ? RX_IDLE : RX_DATA;
          next_st.phase = 1'b0;
          next_st.cnt = '0;
          next_st.par = parOdd;
        end
      RX_DATA:
        if (sampleNow)
        begin
          next_st.shift = {rxIn, st.shift[7:1]};
          next_st.par = st.par ^ rxIn;
          next_st.cnt = st.cnt + 3'h1;
          if (st.cnt == (sevenBit ? 3'h6 : 3'h7))
            next_st.fsm = parEn ? RX_PARITY : RX_STOP;
        end
      RX_PARITY:
        if (sampleNow)
        begin
          next_st.par = st.par ^ rxIn;
          next_st.fsm = RX_STOP;
        end
      RX_STOP:
        if (sampleNow)
        begin
          next_st.fsm = RX_IDLE;
          next_st.done = 1'b1;
          // seven-bit frames land in bits 0..6, top bit zero
          next_st.data = sevenBit ? {1'b0, st.shift[7:1]} : st.shift;
          next_st.pErr = parEn & st.par;
          next_st.fErr = ~rxIn;
        end
    endcase
    // a frame finishing after the enable drops is not reported
    if (!enable)
    begin
      next_st.fsm = RX_IDLE;
      next_st.done = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '{fsm: RX_IDLE, default: '0};
    else
      st <= next_st;
  end

  assign frameDone = st.done;
  assign frameData = st.data;
  assign parityErr = st.pErr;
  assign framingErr = st.fErr;
endmodule

// *** hdl/ast_uart.sv ***
// full-duplex asynchronous serial transceiver with register port
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
// What this block does
// - read-only receive_error_status reports error kind; low three bits reset zero.
// - baud_divider_control is writable, resets to 0x10, top bit unused.
// - transmit only while transmit_enable_bit (mode bit 7) is one.
// - writing transmit_data_register while no frame is in flight starts a serial frame with that byte.
// - receive only while receive_enable_bit (mode bit 6) is one; sample input.
// - input is sampled with the baud generator's serial clock.
// - a completed received frame raises the receive completion interrupt.
// - received data goes to receive_buffer_register even with an error.
// - error_interrupt_suppress set blocks receive interrupt for bad frames.
// - baud = source / (2^(n+1) * (k+16)).
// - n comes from a three-bit prescale field, values zero to seven.
// - counter setting k accepts only zero through fourteen.
// - external baud pin may replace main clock as counter source.
// - seven-bit mode sends only bits 0..6 of the written byte.
// - seven-bit mode stores data in bits 0..6, top bit reads zero.
// - transmit register write-only resets all ones; receive buffer read-only resets zero.
// - frame end sets transmit_done_flag or receive_done_flag, each an interrupt.
module ast_uart
  import ast_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // serial pins
  input wire logic rxd,
  output logic txd,
  input wire logic baudClkPin,
  // interrupt
  output logic irq
);
  typedef struct packed {
    logic [7:0] mode;
    logic [6:0] baud;
    logic [2:0] err;
    logic [7:0] txData;
    logic [7:0] rxBuf;
    logic rxFull;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic [7:0] rdData;
    logic txBusy;
    logic txPhase;
    logic [3:0] txLeft;
    logic [10:0] txFrame;
    logic txLine;
  } ast_uart_state_type;

  ast_uart_state_type st;
  ast_uart_state_type next_st;

  // wires between the sub-blocks
  logic halfTick;
  logic rxDone;
  logic [7:0] rxData;
  logic rxParErr;
  logic rxFrmErr;
  logic txEn;
  logic rxEn;
  logic wrHit;
  logic rdHit;
  logic [1:0] irqSet;
  logic rxFlagSet;
  logic txFlagSet;
  logic txBitEnd;

  assign txEn = st.mode[MODE_TXE];
  assign rxEn = st.mode[MODE_RXE];
  assign txBitEnd = halfTick && st.txPhase;

  // baud generator runs whenever either direction is on
  ast_baud u_baud (
    .clk(clk),
    .rst_n(rst_n),
    .run(txEn | rxEn),
    .extSel(st.mode[MODE_EXTCLK]),
    .prescSel(st.baud[BAUD_N_HI:BAUD_N_LO]),
    .divSet(st.baud[BAUD_K_HI:0]),
    .extClk(baudClkPin),
    .halfTick(halfTick)
  );

  // receiver is clocked by the baud tick and gated by the enable bit
  ast_rx u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .enable(rxEn),
    .halfTick(halfTick),
    .sevenBit(st.mode[MODE_SEVEN]),
    .parEn(st.mode[MODE_PAR_EN]),
    .parOdd(st.mode[MODE_PAR_ODD]),
    .rxIn(rxd),
    .frameDone(rxDone),
    .frameData(rxData),
    .parityErr(rxParErr),
    .framingErr(rxFrmErr)
  );

  // builds a frame, start bit at bit 0, stop bits padding the top
  function automatic logic [10:0] build_frame(input logic [7:0] d, input logic seven,
                                              input logic parEn, input logic odd);
    logic p;
    logic [10:0] f;
    p = odd ^ (seven ? ^d[6:0] : ^d);
    f = '1;
    if (seven)
    begin
      f[7:0] = {d[6:0], 1'b0};
      if (parEn)
        f[8] = p;
    end
    else
    begin
      f[8:0] = {d, 1'b0};
      if (parEn)
        f[9] = p;
    end
    return f;
  endfunction

  // register port decode
  assign wrHit = regWr;
  assign rdHit = regRd;

  // a bad frame raises no receive interrupt while suppression is set
  assign rxFlagSet = rxDone && !((rxParErr | rxFrmErr | (st.rxFull & rxDone))
                     && st.mode[MODE_ERR_SUPPRESS]);
  assign txFlagSet = st.txBusy && txBitEnd && (st.txLeft == 4'h1);
  assign irqSet = {rxFlagSet, txFlagSet};

  // main next-state logic: registers, transmitter, flags
  always_comb
  begin
    next_st = st;
    // read data is returned in the cycle after the strobe only
    next_st.rdData = '0;
    if (rdHit)
    begin
      unique case (regAddr)
        OFS_MODE: next_st.rdData = st.mode;
        OFS_ERR: next_st.rdData = {5'h00, st.err};
        OFS_BAUD: next_st.rdData = {1'b0, st.baud};
        OFS_TXDATA: next_st.rdData = '0;
        OFS_RXBUF: next_st.rdData = st.rxBuf;
        OFS_IRQSTAT: next_st.rdData = {6'h00, st.irqStat};
        OFS_IRQMASK: next_st.rdData = {6'h00, st.irqMask};
        OFS_STATE: next_st.rdData = {6'h00, st.rxFull, st.txBusy};
      endcase
      // reading the buffer frees it for the next frame
      if (regAddr == OFS_RXBUF)
        next_st.rxFull = 1'b0;
    end

    // software writes; status registers ignore them except clear bits
    if (wrHit)
    begin
      unique case (regAddr)
        OFS_MODE: next_st.mode = regWrData;
        OFS_BAUD: next_st.baud = regWrData[6:0];
        OFS_TXDATA: next_st.txData = regWrData;
        OFS_IRQSTAT: next_st.irqStat = st.irqStat & ~regWrData[1:0];
        OFS_IRQMASK: next_st.irqMask = regWrData[1:0];
        default: ;
      endcase
    end

    // transmitter: a bit lasts two half ticks
    if (st.txBusy)
    begin
      if (halfTick)
        next_st.txPhase = ~st.txPhase;
      if (txBitEnd)
      begin
        next_st.txFrame = {1'b1, st.txFrame[10:1]};
        next_st.txLeft = st.txLeft - 4'h1;
        if (st.txLeft == 4'h1)
          next_st.txBusy = 1'b0;
      end
    end
    // clearing the enable aborts a frame and leaves the line idle
    if (!txEn)
    begin
      next_st.txBusy = 1'b0;
      next_st.txFrame = '1;
    end
    // a write while busy updates the register but does not restart the frame
    else if (wrHit && regAddr == OFS_TXDATA && !st.txBusy)
    begin
      next_st.txBusy = 1'b1;
      next_st.txPhase = 1'b0;
      next_st.txFrame = build_frame(regWrData, st.mode[MODE_SEVEN],
                                    st.mode[MODE_PAR_EN], st.mode[MODE_PAR_ODD]);
      next_st.txLeft = TX_BITS_BASE + {3'h0, st.mode[MODE_PAR_EN]}
                       - {3'h0, st.mode[MODE_SEVEN]};
    end
    next_st.txLine = next_st.txFrame[0];

    // frame completion: data moves to the buffer, errors recorded
    if (rxDone)
    begin
      next_st.rxBuf = rxData;
      next_st.rxFull = 1'b1;
      next_st.err = '0;
      next_st.err[ERR_PARITY] = rxParErr;
      next_st.err[ERR_FRAMING] = rxFrmErr;
      // unread previous byte is overwritten and flagged
      next_st.err[ERR_OVERRUN] = st.rxFull && !(rdHit && regAddr == OFS_RXBUF);
    end

    // hardware set wins over a software clear in the same cycle
    next_st.irqStat = next_st.irqStat | irqSet;
  end

  // state register with documented reset values
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.mode <= MODE_RESET;
      st.baud <= BAUD_RESET;
      st.err <= ERR_RESET[2:0];
      st.txData <= TXDATA_RESET;
      st.rxBuf <= RXBUF_RESET;
      st.txFrame <= '1;
      st.txLine <= 1'b1;
    end
    else
      st <= next_st;
  end

  // outputs: line and read data come straight from flip-flops
  assign txd = st.txLine;
  assign regRdData = st.rdData;
  // level interrupt while any unmasked flag is set
  assign irq = |(st.irqStat & st.irqMask);
endmodule

// *** sim/ast_uart_props.sv ***
// concurrent checks on the transceiver register port and serial pins
`timescale 1ns/1ns
module ast_uart_props
  import ast_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // serial pins and interrupt
  input wire logic rxd,
  input wire logic txd,
  input wire logic baudClkPin,
  input wire logic irq
);
  logic [7:0] mode;
  logic [6:0] baud;
  logic [1:0] mask;
  logic [8:0] highCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shadows of writable registers; quiet count tells an idle transmitter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= MODE_RESET;
      baud <= BAUD_RESET;
      mask <= 2'h0;
      highCnt <= 9'h000;
    end
    else
    begin
      if (regWr && regAddr == OFS_MODE)
        mode <= regWrData;
      if (regWr && regAddr == OFS_BAUD)
        baud <= regWrData[6:0];
      if (regWr && regAddr == OFS_IRQMASK)
        mask <= regWrData[1:0];
      highCnt <= !txd ? 9'h000 : highCnt + {8'h00, highCnt != 9'h1FF};
    end
  end
  sequence sRd(logic [2:0] a);
    regRd && regAddr == a;
  endsequence
  // long quiet line means no frame in flight, so a write must start one
  sequence sTxGo;
    regWr && regAddr == OFS_TXDATA && mode[MODE_TXE] && highCnt > 9'h190;
  endsequence
  a_txdata_unread: assert property (sRd(OFS_TXDATA) |=> regRdData == 8'h00)
    else $error("transmit data register read back nonzero");
  a_baud_readback: assert property (sRd(OFS_BAUD) |=> regRdData == {1'b0, $past(baud)})
    else $error("baud divider readback wrong");
  a_mode_readback: assert property (sRd(OFS_MODE) |=> regRdData == $past(mode))
    else $error("mode readback wrong");
  a_tx_blocked: assert property (!mode[MODE_TXE] |-> ##[1:2] txd)
    else $error("txd active with transmit disabled");
  a_tx_start: assert property (sTxGo |=> !txd)
    else $error("no start bit after transmit write");
  a_irq_masked: assert property (mask == 2'h0 |-> !irq)
    else $error("interrupt with all sources masked");
  a_rx_blocked: assert property (
    !mode[MODE_RXE] && mask == 2'h2 && !irq ##1 mask == 2'h2 |-> !irq)
    else $error("receive interrupt with receive disabled");
  a_rx_seven_msb: assert property (
    regRd && regAddr == OFS_RXBUF && mode[MODE_SEVEN] |=> !regRdData[7])
    else $error("receive buffer top bit set in seven-bit mode");
endmodule
bind ast_uart ast_uart_props chk (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .rxd(rxd), .txd(txd), .baudClkPin(baudClkPin), .irq(irq));

// *** sim/ast_remote.sv ***
// remote serial device model: sends frames on rxd, decodes frames from txd
`timescale 1ns/1ns
module ast_remote (
  // clock and serial pins
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  // line setup in clocks per bit
  input wire logic [7:0] bitLen,
  input wire logic sevenBit,
  // decoded frame
  output logic [7:0] gotByte,
  output logic gotStrobe
);
  // idle line is pulled high
  initial rxd = 1'b1;
  initial gotStrobe = 1'b0;
  // one frame lsb first; a bad frame holds its stop bit low for a whole bit
  task automatic sendFrame(input logic [7:0] d, input logic bad);
    @(posedge clk) rxd <= 1'b0;
    repeat (bitLen) @(posedge clk);
    for (int i = 0; i < (sevenBit ? 7 : 8); i++)
    begin
      rxd <= d[i];
      repeat (bitLen) @(posedge clk);
    end
    rxd <= ~bad;
    repeat (bitLen) @(posedge clk);
    rxd <= 1'b1;
  endtask
  // decode txd at mid-bit; a low stop bit drops the frame
  always
  begin
    @(negedge txd);
    repeat (bitLen / 2) @(posedge clk);
    gotByte = 8'h00;
    for (int i = 0; i < (sevenBit ? 7 : 8); i++)
    begin
      repeat (bitLen) @(posedge clk);
      gotByte[i] = txd;
    end
    repeat (bitLen) @(posedge clk);
    gotStrobe = txd;
    @(posedge clk) gotStrobe = 1'b0;
  end
endmodule

// *** sim/ast_uart_tb.sv ***
// self-checking testbench for the asynchronous serial transceiver
`timescale 1ns/1ns
module ast_uart_tb
  import ast_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic rxd;
  logic txd;
  logic baudClkPin = 1'b0;
  logic irq;
  logic [7:0] bitLen = 8'h20;
  logic sevenBit = 1'b0;
  logic [7:0] gotByte;
  logic gotStrobe;
  logic extRun = 1'b0;
  logic rdLast = 1'b0;
  logic [15:0] e;
  logic [15:0] rdQ[$];
  logic [7:0] txQ[$];
  logic [7:0] b;
  int fails = 0;
  int samples_checked = 0;
  integer seed = 86;
  ast_uart uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxd(rxd), .txd(txd),
    .baudClkPin(baudClkPin), .irq(irq));
  ast_remote rem (.clk(clk), .txd(txd), .rxd(rxd), .bitLen(bitLen), .sevenBit(sevenBit),
    .gotByte(gotByte), .gotStrobe(gotStrobe));
  always #50 clk = ~clk;
  // external baud source: one rising edge every two clocks
  always @(posedge clk) if (extRun) baudClkPin <= ~baudClkPin;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // strobes drop with a gap cycle so no signal is assigned twice in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] x);
    rdQ.push_back({m, x & m});
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic waitIrq(input logic x);
    for (int i = 0; i < 1000 && irq !== 1'b1; i++)
      @(posedge clk);
    check({7'h00, irq}, {7'h00, x});
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rdLast)
    begin
      e = rdQ.pop_front();
      check(regRdData & e[15:8], e[7:0]);
    end
    rdLast <= regRd;
  end
  // an unexpected byte meets an unknown note and fails
  always @(posedge gotStrobe) check(gotByte, txQ.size() ? txQ.pop_front() : 8'hXX);
  initial
  begin
    #5000000;
    fails++;
    give_verdict;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_MODE, 8'hFF, MODE_RESET);
    rd(OFS_ERR, 8'h07, 8'h00);
    rd(OFS_BAUD, 8'hFF, 8'h10);
    rd(OFS_RXBUF, 8'hFF, 8'h00);
    rd(OFS_TXDATA, 8'hFF, 8'h00);
    rd(OFS_IRQSTAT, 8'h03, 8'h00);
    $display("test reset values done");
    for (int n = 0; n < 8; n++)
    begin
      b = {n[0], 3'(n), 4'($unsigned($random(seed)) % 15)};
      wr(OFS_BAUD, b);
      rd(OFS_BAUD, 8'hFF, {1'b0, b[6:0]});
    end
    $display("test baud register done");
    wr(OFS_BAUD, 8'h00);
    wr(OFS_IRQMASK, 8'h02);
    wr(OFS_TXDATA, 8'hA5);
    rem.sendFrame(8'h3C, 1'b0);
    waitIrq(1'b0);
    $display("test disabled link done");
    wr(OFS_IRQMASK, 8'h03);
    // fast, slower divided and external source: each way twice
    for (int c = 0; c < 3; c++)
    begin
      wr(OFS_BAUD, c == 1 ? 8'h12 : 8'h00);
      wr(OFS_MODE, c == 2 ? 8'hD0 : 8'hC0);
      extRun <= (c == 2);
      bitLen <= c == 0 ? 8'h20 : (c == 1 ? 8'h48 : 8'h40);
      repeat (2)
      begin
        b = 8'($random(seed));
        txQ.push_back(b);
        wr(OFS_TXDATA, b);
        waitIrq(1'b1);
        rd(OFS_IRQSTAT, 8'h03, 8'h01);
        wr(OFS_IRQSTAT, 8'h01);
        check({7'h00, irq}, 8'h00);
        rem.sendFrame(~b, 1'b0);
        waitIrq(1'b1);
        rd(OFS_RXBUF, 8'hFF, ~b);
        wr(OFS_IRQSTAT, 8'h02);
      end
    end
    $display("test baud sources done");
    extRun <= 1'b0;
    bitLen <= 8'h20;
    // good and bad frames, with and without error suppression
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($random(seed));
      wr(OFS_MODE, i[1] ? 8'hC2 : 8'hC0);
      rem.sendFrame(b, i[0]);
      waitIrq(!(i[0] && i[1]));
      rd(OFS_RXBUF, 8'hFF, b);
      rd(OFS_ERR, 8'h07, {6'h00, i[0], 1'b0});
      wr(OFS_IRQSTAT, 8'h03);
    end
    // two frames with no read between: the second overruns and is suppressed
    rem.sendFrame(8'h5A, 1'b0);
    rem.sendFrame(8'h96, 1'b0);
    repeat (4) @(posedge clk);
    waitIrq(1'b1);
    rd(OFS_RXBUF, 8'hFF, 8'h96);
    rd(OFS_ERR, 8'h07, 8'h01);
    wr(OFS_IRQSTAT, 8'h03);
    $display("test receive errors done");
    // seven data bits plus parity look like one eight-bit byte to the remote
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_MODE, i[0] ? 8'hCD : 8'hC9);
      b = 8'($random(seed));
      txQ.push_back({i[0] ^ (^b[6:0]), b[6:0]});
      wr(OFS_TXDATA, b);
      waitIrq(1'b1);
      wr(OFS_IRQSTAT, 8'h01);
      rem.sendFrame(b, 1'b0);
      waitIrq(1'b1);
      rd(OFS_RXBUF, 8'hFF, b & 8'h7F);
      rd(OFS_ERR, 8'h07, {5'h00, b[7] ^ i[0] ^ (^b[6:0]), 2'h0});
      wr(OFS_IRQSTAT, 8'h03);
    end
    $display("test parity done");
    wr(OFS_MODE, 8'hC1);
    sevenBit <= 1'b1;
    rd(OFS_MODE, 8'hFF, 8'hC1);
    b = 8'($random(seed)) | 8'h80;
    txQ.push_back(b & 8'h7F);
    wr(OFS_TXDATA, b);
    waitIrq(1'b1);
    wr(OFS_IRQSTAT, 8'h01);
    rem.sendFrame(b, 1'b0);
    waitIrq(1'b1);
    rd(OFS_RXBUF, 8'hFF, b & 8'h7F);
    @(posedge clk);
    check(8'(txQ.size() + rdQ.size()), 8'h00);
    $display("test seven-bit done");
    give_verdict;
  end
endmodule
